// ---- mta_defines.svh ----
`ifndef MTA_DEFINES_SVH
`define MTA_DEFINES_SVH
// Function
// - internal source: free run if continuous, else one reading per arm command
// - external source: one reading per trigger; single mode needs re-arming each time
// - only host clears continuation; local return or power-up restores it on
// - external trigger from front key, external I/O line or host command
// - optional programmable wait 0 to 10000 ms before sampling; off by default
// - internal continuous triggering uses a moving average over recent readings
// - internal single triggering uses a simple average over the count
// - external triggering always uses simple averaging
// - moving average publishes readings before the count is reached
// - simple averaging publishes only when the count is reached
// - accumulator clears on condition change and when all errors clear

// ----------------------------------------------------------------
// register word indexes (byte offset = index * 4)
// ----------------------------------------------------------------
`define MTA_IX_CTRL   6'h00
`define MTA_IX_DELAY  6'h01
`define MTA_IX_AVG    6'h02
`define MTA_IX_CMD    6'h03
`define MTA_IX_STAT   6'h04
`define MTA_IX_RES    6'h05

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MTA_B_EXT     0
`define MTA_B_CONT    1
`define MTA_B_DLYEN   2
`define MTA_B_AVGEN   3
`define MTA_B_ARM     0
`define MTA_B_TRIG    1

// ----------------------------------------------------------------
// limits, reset values and timing
// ----------------------------------------------------------------
`define MTA_DLY_MAX   14'h2710
`define MTA_RST_CTRL  4'h2
`define MTA_MS_NS     1000000
`define MTA_CLK_NS    100
`define MTA_HTRANS_NS 2'h2
`define MTA_HTRANS_SQ 2'h3
`endif

// ---- mta_pkg.sv ----
`default_nettype none
package mta_pkg;
    // measurement sequencing states
    typedef enum logic [1:0] {
        MTA_IDLE,
        MTA_WAIT,
        MTA_SAMP
    } mta_state_e;

    // whole state of the block apart from the window memory
    typedef struct packed {
        mta_state_e  state;
        logic        ext;
        logic        cont;
        logic        dly_en;
        logic        avg_en;
        logic [13:0] dly_ms;
        logic [7:0]  avg_m1;
        logic        armed;
        logic [13:0] ms_left;
        logic [13:0] tick;
        logic        req;
        logic [31:0] sum;
        logic [8:0]  cnt;
        logic [7:0]  wptr;
        logic [23:0] result;
        logic        res_valid;
        logic        stb;
        logic [1:0]  err;
        logic        dp_wr;
        logic [5:0]  dp_ix;
        logic [31:0] rdata;
    } mta_st_s;
endpackage : mta_pkg
`default_nettype wire

// ---- mta_trig_avg.sv ----
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "mta_defines.svh"
module mta_trig_avg #(
    parameter int MS_CYCLES = `MTA_MS_NS / `MTA_CLK_NS
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic        key_trig,
    input  wire logic        io_trig,
    input  wire logic        local_return,
    input  wire logic        cond_change,
    output logic             sample_req,
    input  wire logic        sample_valid,
    input  wire logic [23:0] sample_data,
    input  wire logic [1:0]  sample_err,
    output logic             result_stb,
    output logic      [23:0] result_data
);
    // ----------------------------------------------------------------
    // state and window memory
    // ----------------------------------------------------------------
    mta_pkg::mta_st_s q;
    mta_pkg::mta_st_s d;
    logic [23:0]      win_mem [256];

    localparam logic [13:0] TICK_LAST = 14'(MS_CYCLES - 1);
    // reset word held as a parameter so its fields can be picked out by position
    localparam logic [3:0]  RST_CTRL  = `MTA_RST_CTRL;

    logic        addr_ph;
    logic        wr_ctrl;
    logic        wr_dly;
    logic        wr_avg;
    logic        wr_cmd;
    logic        host_trig;
    logic        ext_evt;
    logic        fire;
    logic        moving;
    logic [8:0]  need;
    logic        ovr;
    logic [31:0] acc_sum;
    logic [8:0]  acc_cnt;
    logic [31:0] avg_val;
    logic        good;
    logic        clr_acc;
    logic [13:0] wdly;

    // bus always ready, never errors; zero wait states
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = q.rdata;
    assign sample_req  = q.req;
    assign result_stb  = q.stb;
    assign result_data = q.result;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    // writes land in the data phase after the captured address
    assign addr_ph = hsel && hready && htrans[1];
    assign wr_ctrl = q.dp_wr && (q.dp_ix == `MTA_IX_CTRL);
    assign wr_dly  = q.dp_wr && (q.dp_ix == `MTA_IX_DELAY);
    assign wr_avg  = q.dp_wr && (q.dp_ix == `MTA_IX_AVG);
    assign wr_cmd  = q.dp_wr && (q.dp_ix == `MTA_IX_CMD);
    assign host_trig = wr_cmd && hwdata[`MTA_B_TRIG];
    // out-of-range delay is clamped rather than refused
    assign wdly = (hwdata[31:14] != 18'h0 || hwdata[13:0] > `MTA_DLY_MAX)
                ? `MTA_DLY_MAX : hwdata[13:0];

    // ----------------------------------------------------------------
    // trigger acceptance
    // ----------------------------------------------------------------
    // key, I/O line and host command all count as external events
    assign ext_evt = key_trig || io_trig || host_trig;
    // triggers arriving while busy are dropped, not queued
    assign fire = (q.state == mta_pkg::MTA_IDLE)
               && (q.cont || q.armed)
               && (!q.ext || ext_evt);

    // ----------------------------------------------------------------
    // averaging arithmetic
    // ----------------------------------------------------------------
    // moving only for internal continuous; everything else is simple
    assign moving = !q.ext && q.cont && q.avg_en;
    // count-1 stored so 256 fits in eight bits
    assign need = q.avg_en ? ({1'b0, q.avg_m1} + 9'h001) : 9'h001;
    assign ovr = moving && (q.cnt == need);
    // full window: oldest reading leaves as the new one enters
    assign acc_sum = q.sum + {8'h00, sample_data}
                   - (ovr ? {8'h00, win_mem[q.wptr]} : 32'h0);
    assign acc_cnt = ovr ? q.cnt : q.cnt + 9'h001;
    assign avg_val = acc_sum / {23'h0, acc_cnt};
    assign good = sample_valid && (sample_err == 2'h0)
               && (q.state == mta_pkg::MTA_SAMP);
    // combined function: wait until both error flags have cleared
    assign clr_acc = cond_change || wr_ctrl || wr_avg
                  || ((q.err != 2'h0) && (sample_err == 2'h0));

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.req = 1'b0;
        d.stb = 1'b0;
        d.err = sample_err;

        // bus address phase capture and registered read data
        d.dp_wr = addr_ph && hwrite;
        d.dp_ix = haddr[7:2];
        if (addr_ph && !hwrite && haddr[31:8] == 24'h0)
        begin
            case (haddr[7:2])
                `MTA_IX_CTRL:  d.rdata = {28'h0, q.avg_en, q.dly_en, q.cont, q.ext};
                `MTA_IX_DELAY: d.rdata = {18'h0, q.dly_ms};
                `MTA_IX_AVG:   d.rdata = {24'h0, q.avg_m1};
                `MTA_IX_STAT:  d.rdata = {19'h0, q.cnt, q.res_valid,
                                         q.state == mta_pkg::MTA_SAMP,
                                         q.state == mta_pkg::MTA_WAIT, q.armed};
                `MTA_IX_RES:   d.rdata = {8'h0, q.result};
                default:       d.rdata = 32'h0;
            endcase
        end
        else
        begin
            d.rdata = 32'h0;
        end

        // configuration writes
        if (wr_ctrl)
        begin
            d.ext    = hwdata[`MTA_B_EXT];
            d.cont   = hwdata[`MTA_B_CONT];
            d.dly_en = hwdata[`MTA_B_DLYEN];
            d.avg_en = hwdata[`MTA_B_AVGEN];
        end
        if (wr_dly)
        begin
            d.dly_ms = wdly;
        end
        if (wr_avg)
        begin
            d.avg_m1 = hwdata[7:0];
        end
        // going local outranks a host write in the same cycle
        if (local_return)
        begin
            d.cont = 1'b1;
        end
        if (wr_cmd && hwdata[`MTA_B_ARM])
        begin
            d.armed = 1'b1;
        end

        // sequencing
        case (q.state)
            mta_pkg::MTA_IDLE:
            begin
                if (fire)
                begin
                    // single shot consumes the arm; arm and fire together leave it clear
                    if (!q.cont)
                    begin
                        d.armed = 1'b0;
                    end
                    if (q.dly_en && q.dly_ms != 14'h0)
                    begin
                        d.state   = mta_pkg::MTA_WAIT;
                        d.ms_left = q.dly_ms;
                        d.tick    = 14'h0;
                    end
                    else
                    begin
                        d.state = mta_pkg::MTA_SAMP;
                        d.req   = 1'b1;
                    end
                end
            end
            mta_pkg::MTA_WAIT:
            begin
                // millisecond enable from the cycle divider
                if (q.tick == TICK_LAST)
                begin
                    d.tick    = 14'h0;
                    d.ms_left = q.ms_left - 14'h1;
                    if (q.ms_left == 14'h1)
                    begin
                        d.state = mta_pkg::MTA_SAMP;
                        d.req   = 1'b1;
                    end
                end
                else
                begin
                    d.tick = q.tick + 14'h1;
                end
            end
            mta_pkg::MTA_SAMP:
            begin
                if (sample_valid && !good)
                begin
                    // failed reading ends the measurement unpublished
                    d.state = mta_pkg::MTA_IDLE;
                end
                else if (good)
                begin
                    d.sum = acc_sum;
                    d.cnt = acc_cnt;
                    if (moving)
                    begin
                        d.wptr = (q.wptr == q.avg_m1) ? 8'h00 : q.wptr + 8'h01;
                        d.result    = avg_val[23:0];
                        d.res_valid = 1'b1;
                        d.stb       = 1'b1;
                        d.state     = mta_pkg::MTA_IDLE;
                    end
                    else if (acc_cnt == need)
                    begin
                        d.result    = avg_val[23:0];
                        d.res_valid = 1'b1;
                        d.stb       = 1'b1;
                        d.sum       = 32'h0;
                        d.cnt       = 9'h0;
                        d.state     = mta_pkg::MTA_IDLE;
                    end
                    else
                    begin
                        d.req = 1'b1;
                    end
                end
            end
            default:
            begin
                d.state = mta_pkg::MTA_IDLE;
            end
        endcase

        // a condition change wipes the running average
        if (clr_acc)
        begin
            d.sum  = 32'h0;
            d.cnt  = 9'h0;
            d.wptr = 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // reset values: internal, continuous, no delay, no averaging
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q        <= '0;
            q.state  <= mta_pkg::MTA_IDLE;
            q.ext    <= RST_CTRL[`MTA_B_EXT];
            q.cont   <= RST_CTRL[`MTA_B_CONT];
            q.dly_en <= RST_CTRL[`MTA_B_DLYEN];
            q.avg_en <= RST_CTRL[`MTA_B_AVGEN];
        end
        else
        begin
            q <= d;
        end
    end

    // window memory keeps the last readings of the moving average
    always_ff @(posedge hclk)
    begin
        if (good && moving)
        begin
            win_mem[q.wptr] <= sample_data;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_dly_fire;
        fire && q.dly_en && (q.dly_ms != 14'h0);
    endsequence

    sequence s_quiet;
        (!sample_req)[*8];
    endsequence

    property p_free_run;
        @(posedge hclk) disable iff (!hresetn)
        (q.state == mta_pkg::MTA_IDLE) && !q.ext && q.cont
        |-> ##1 (q.state != mta_pkg::MTA_IDLE);
    endproperty
    a_free_run: assert property (p_free_run)
        else $error("internal free run did not start");

    property p_single_disarm;
        @(posedge hclk) disable iff (!hresetn)
        fire && !q.cont && !(wr_cmd && hwdata[`MTA_B_ARM]) |=> !q.armed;
    endproperty
    a_single_disarm: assert property (p_single_disarm)
        else $error("single shot left armed");

    property p_ext_wait;
        @(posedge hclk) disable iff (!hresetn)
        (q.state == mta_pkg::MTA_IDLE) && q.ext && !ext_evt
        |=> (q.state == mta_pkg::MTA_IDLE);
    endproperty
    a_ext_wait: assert property (p_ext_wait)
        else $error("external mode ran without a trigger");

    property p_cont_back;
        @(posedge hclk) disable iff (!hresetn)
        local_return |=> q.cont;
    endproperty
    a_cont_back: assert property (p_cont_back)
        else $error("continuation not restored");

    property p_dly_hold;
        @(posedge hclk) disable iff (!hresetn)
        s_dly_fire |=> s_quiet;
    endproperty
    a_dly_hold: assert property (p_dly_hold)
        else $error("sampling started inside delay");

    property p_move_pub;
        @(posedge hclk) disable iff (!hresetn)
        good && moving |=> result_stb && (result_data == $past(avg_val[23:0]));
    endproperty
    a_move_pub: assert property (p_move_pub)
        else $error("moving average not published");

    property p_simple_hold;
        @(posedge hclk) disable iff (!hresetn)
        good && !moving && (acc_cnt != need) |=> !result_stb ##1 !result_stb;
    endproperty
    a_simple_hold: assert property (p_simple_hold)
        else $error("simple average published early");

    property p_clear;
        @(posedge hclk) disable iff (!hresetn)
        cond_change |=> (q.cnt == 9'h0) && (q.sum == 32'h0);
    endproperty
    a_clear: assert property (p_clear)
        else $error("accumulator not cleared");

    property p_ext_simple;
        @(posedge hclk) disable iff (!hresetn)
        good && q.ext |=> (q.wptr == $past(q.wptr)) || $past(clr_acc);
    endproperty
    a_ext_simple: assert property (p_ext_simple)
        else $error("external trigger used moving window");
endmodule : mta_trig_avg
`default_nettype wire

// ---- mta_adc_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// a/d converter model: one reading per request, lat+1 cycles after it
// ----------------------------------------------------------------
module mta_adc_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        sample_req,
    input  wire logic [3:0]  lat,
    input  wire logic [23:0] data_in,
    input  wire logic [1:0]  err_in,
    output logic             sample_valid,
    output logic      [23:0] sample_data,
    output logic      [1:0]  sample_err
);
    logic [3:0] wait_q;
    logic       busy_q;

    // data lines toggle outside valid so a stale value is never mistaken for a reading
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            busy_q       <= 1'b0;
            wait_q       <= 4'h0;
            sample_valid <= 1'b0;
            sample_data  <= 24'h000000;
        end
        else
        begin
            sample_valid <= 1'b0;
            sample_data  <= ~sample_data;
            if (sample_req)
            begin
                busy_q <= 1'b1;
                wait_q <= lat;
            end
            else if (busy_q && wait_q != 4'h0)
                wait_q <= wait_q - 4'h1;
            else if (busy_q)
            begin
                busy_q       <= 1'b0;
                sample_valid <= 1'b1;
                sample_data  <= data_in;
            end
        end
    end

    // error flags only show beside a reading, so they clear right after it
    assign sample_err = sample_valid ? err_in : 2'h0;
endmodule : mta_adc_model
`default_nettype wire

// ---- mta_trig_avg_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "mta_defines.svh"
module mta_trig_avg_tb;
    localparam int MSC = 8;
    typedef struct packed {
        logic        wr;
        logic [5:0]  ix;
        logic [31:0] d;
    } mta_row_s;
    // register table: writes, and reads beside the value they must return
    mta_row_s    rows [11] = '{
        '{1'b0, `MTA_IX_CTRL, 32'h2}, '{1'b0, `MTA_IX_DELAY, 32'h0},
        '{1'b0, `MTA_IX_AVG, 32'h0}, '{1'b0, `MTA_IX_CMD, 32'h0}, '{1'b0, 6'h06, 32'h0},
        '{1'b1, `MTA_IX_DELAY, 32'h3000}, '{1'b0, `MTA_IX_DELAY, 32'h2710},
        '{1'b1, `MTA_IX_AVG, 32'hFF}, '{1'b0, `MTA_IX_AVG, 32'hFF},
        '{1'b1, 6'h06, 32'hFFFFFFFF}, '{1'b0, 6'h06, 32'h0}};
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0]  htrans = 2'h0, err_in = 2'h0, sample_err;
    logic        key_trig = 1'b0, io_trig = 1'b0, local_return = 1'b0, cond_change = 1'b0;
    logic        sample_req, sample_valid, result_stb, hresp;
    logic [23:0] sample_data, result_data, last_smp, b, data_in = 24'h000100;
    logic [3:0]  lat = 4'h2;
    logic [23:0] res_q [$], smp_q [$];
    int          miscompares = 0, checks_done = 0, cycles = 0, n_req = 0, req_cyc = 0;
    int          t0, d0, d1, k;

    always #50 hclk = ~hclk;

    mta_trig_avg #(.MS_CYCLES(MSC)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .key_trig(key_trig),
        .io_trig(io_trig), .local_return(local_return), .cond_change(cond_change),
        .sample_req(sample_req), .sample_valid(sample_valid), .sample_data(sample_data),
        .sample_err(sample_err), .result_stb(result_stb), .result_data(result_data));

    mta_adc_model u_adc (
        .hclk(hclk), .hresetn(hresetn), .sample_req(sample_req), .lat(lat),
        .data_in(data_in), .err_in(err_in), .sample_valid(sample_valid),
        .sample_data(sample_data), .sample_err(sample_err));

    // ----------------------------------------------------------------
    // monitor: counts requests, logs results, ramps the converter data
    // ----------------------------------------------------------------
    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (sample_req) n_req <= n_req + 1;
        if (sample_req) req_cyc <= cycles;
        if (sample_valid) last_smp <= sample_data;
        if (sample_valid) data_in <= data_in + 24'h1;
        if (result_stb) res_q.push_back(result_data);
        if (result_stb) smp_q.push_back(last_smp);
        if (cycles == 20000)
        begin
            miscompares++;
            complete_run();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %0t %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask : chk

    // single word transfer; waits on hready at both phases
    task automatic bus(input logic wr, input logic [5:0] ix, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, ix, 2'h0};
        hwrite <= wr;
        htrans <= `MTA_HTRANS_NS;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        rd = hrdata;
    endtask : bus

    // 0 key, 1 i/o line, 2 host trigger, 3 arm, other: nothing
    task automatic fire(input int s);
        t0 = cycles;
        if (s == 2 || s == 3)
            bus(1'b1, `MTA_IX_CMD, (s == 2) ? 32'h2 : 32'h1);
        else if (s < 2)
        begin
            key_trig <= (s == 0);
            io_trig <= (s == 1);
            @(posedge hclk);
            key_trig <= 1'b0;
            io_trig <= 1'b0;
        end
    endtask : fire

    task automatic trig_cnt(input int s, input int n);
        int base;
        base = n_req;
        fire(s);
        repeat (40) @(posedge hclk);
        chk(n_req - base, n, "request count");
    endtask : trig_cnt

    task automatic wait_res(input int n);
        for (int i = 0; i < 400 && res_q.size() < n; i++) @(posedge hclk);
    endtask : wait_res

    // one trigger must give exactly one published plain average of four ramp values
    task automatic simple(input logic [3:0] c, input int s);
        bus(1'b1, `MTA_IX_CTRL, {28'h0, c});
        res_q.delete();
        b = data_in;
        fire(s);
        wait_res(1);
        repeat (60) @(posedge hclk);
        chk(res_q.size(), 1, "publish count");
        chk(res_q[0], b + 24'h1, "simple average");
    endtask : simple

    function automatic logic [23:0] mov(input logic [23:0] base, input int i);
        int          n;
        logic [31:0] s;
        n = (i < 3) ? i + 1 : 4;
        s = 0;
        for (int j = i - n + 1; j <= i; j++) s += base + j;
        return 24'(s / n);
    endfunction : mov

    task automatic complete_run;
        if (miscompares == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge hclk);
        chk({hrdata, result_data, 5'h0, hresp, sample_req, result_stb}, 64'h0, "reset outputs");
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (rows[i])
        begin
            bus(rows[i].wr, rows[i].ix, rows[i].d);
            if (!rows[i].wr) chk(rd, rows[i].d, "register");
        end
        bus(1'b1, `MTA_IX_AVG, 32'h3);
        k = n_req;
        repeat (40) @(posedge hclk);
        chk((n_req - k) > 4, 1, "free run");
        bus(1'b1, `MTA_IX_CTRL, 32'h0);
        // a reading fired just before the write lands would otherwise be counted below
        repeat (20) @(posedge hclk);
        trig_cnt(9, 0);
        trig_cnt(3, 1);
        trig_cnt(9, 0);
        bus(1'b1, `MTA_IX_CTRL, 32'h1);
        trig_cnt(1, 0);
        trig_cnt(3, 0);
        trig_cnt(1, 1);
        trig_cnt(0, 0);
        local_return <= 1'b1;
        @(posedge hclk);
        local_return <= 1'b0;
        bus(1'b0, `MTA_IX_CTRL, 32'h0);
        chk(rd, 32'h3, "local return");
        for (int s = 0; s < 3; s++) trig_cnt(s, 1);
        trig_cnt(1, 1);
        d0 = req_cyc - t0;
        // wait kept well above the converter latency
        bus(1'b1, `MTA_IX_DELAY, 32'h2);
        bus(1'b1, `MTA_IX_CTRL, 32'h7);
        trig_cnt(1, 1);
        d1 = req_cyc - t0;
        chk(d1 - d0, 2 * MSC, "delay length");
        bus(1'b1, `MTA_IX_DELAY, 32'h0);
        trig_cnt(1, 1);
        chk(req_cyc - t0, d0, "zero delay");
        lat <= 4'h9;
        simple(4'hB, 1);
        res_q.delete();
        err_in <= 2'h1;
        trig_cnt(1, 1);
        chk(res_q.size(), 0, "error publish");
        err_in <= 2'h0;
        simple(4'hB, 1);
        lat <= 4'h2;
        bus(1'b1, `MTA_IX_CTRL, 32'h0);
        simple(4'h8, 3);
        bus(1'b0, `MTA_IX_RES, 32'h0);
        chk(rd, {8'h0, b + 24'h1}, "result register");
        bus(1'b0, `MTA_IX_STAT, 32'h0);
        chk(rd, 32'h8, "status after single shot");
        res_q.delete();
        smp_q.delete();
        b = data_in;
        bus(1'b1, `MTA_IX_CTRL, 32'hA);
        wait_res(5);
        for (int i = 0; i < 5; i++) chk(res_q[i], mov(b, i), "moving average");
        @(posedge hclk iff result_stb);
        cond_change <= 1'b1;
        @(posedge hclk);
        cond_change <= 1'b0;
        k = res_q.size();
        wait_res(k + 1);
        chk(res_q[k], smp_q[k], "cleared window");
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, `MTA_IX_CTRL, 32'h0);
        chk(rd, 32'h2, "ctrl after reset");
        bus(1'b0, `MTA_IX_AVG, 32'h0);
        chk(rd, 32'h0, "count after reset");
        complete_run();
    end
endmodule : mta_trig_avg_tb
`default_nettype wire
